// >>> rtl/alarm_pkg.sv
/*
  Constants shared by the alarm and interrupt control block: register
  offsets, field positions, reset values and decode figures.
  Assumes an 8-bit register port with a 16-bit register address.
*/
package alarm_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] THERMAL_TRIP_CONFIG_ADDR = 16'h0888;
  localparam logic [15:0] ALARM_MASK_STATUS_ADDR = 16'h0889;
  localparam logic [15:0] INDEX_AMP_ENABLE_ADDR = 16'h088A;
  localparam logic [15:0] COMPARATOR_DISABLE_ADDR = 16'h088B;
  localparam logic [15:0] MISCELLANEOUS_CONTROL_ADDR = 16'h088D;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POWERUP_STATUS_BIT = 7;
  localparam int LED_LOOP_STATUS_BIT = 6;
  localparam int THERMAL_ALARM_STATUS_BIT = 5;
  localparam int SHUTDOWN_STATUS_BIT = 4;
  localparam int LED_LOOP_MASK_BIT = 2;
  localparam int THERMAL_ALARM_MASK_BIT = 1;
  localparam int SHUTDOWN_MASK_BIT = 0;
  localparam int INDEX_AMP_ON_BIT = 2;
  localparam int INDEX_COMPARATOR_OFF_BIT = 2;
  localparam int INTERP_COMPARATOR_OFF_BIT = 1;
  localparam int MAINT_SEL_LSB = 4;
  localparam int TRIP_CODE_WIDTH = 4;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] THERMAL_TRIP_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] INDEX_AMP_RESET = 8'hFF;
  localparam logic [7:0] COMPARATOR_RESET = 8'h00;
  localparam logic [7:0] MAINT_CTRL_RESET = 8'h01;
  localparam logic [7:0] MASK_WRITABLE = 8'h07;
  localparam logic [1:0] MAINT_DISABLED = 2'h0;
  localparam logic [1:0] MAINT_ENABLED = 2'h3;

  // ----------------------------------------
  // Decode figures, degrees Celsius
  // ----------------------------------------
  localparam int TRIP_BASE_DEG = 200;
  localparam int TRIP_STEP_DEG = 9;
  localparam int SHUTDOWN_DEG = 165;
  localparam int TEMP_WIDTH = 9;

endpackage : alarm_pkg

// >>> rtl/alarm_reg_if.sv
/*
  Register-access bundle between the top and its register bank.
  Assumes one clock; strobes are single-cycle pulses.
*/
`timescale 1ns/1ps
interface alarm_reg_if;
  logic wr_en;
  logic rd_en;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic status_read;

  modport bank (input wr_en, input rd_en, input addr, input wdata, output rdata,
    output status_read);
  modport ctrl (output wr_en, output rd_en, output addr, output wdata, input rdata,
    input status_read);
endinterface : alarm_reg_if

// >>> rtl/pin_sync.sv
/*
  Two-flop synchroniser for a bundle of asynchronous levels.
  Assumes the inputs are quasi-static levels, not multi-bit words.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync width must be positive");
  end

  always_comb begin
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= {INIT, INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.sync;
endmodule : pin_sync

// >>> rtl/alarm_interrupt_control.sv
/*
  Alarm and interrupt control: four alarm sources, sticky status bits
  cleared by a register read, masks, open-drain interrupt pin, and the
  signal-path enable and maintenance-output control registers.
  Assumes a register engine on ref_clk issuing single-cycle strobes, and
  analog monitors whose levels arrive asynchronously.
*/
// What this block does
// - Power-up alarm is held from sequence start until sequence completes.
// - LED-loop alarm is held while the LED drive loop is out of regulation.
// - Thermal alarm is held while temperature is above the programmed trip point.
// - Thermal shutdown alarm latches above 165 C until power cycle.
// - A present alarm sets its status bit to one.
// - Status bits stay set until a register read or power-on reset.
// - Shutdown alarm switches off all current-consuming circuitry.
// - Unmasked alarms pull the interrupt pin low; masked ones do not.
// - Power-up alarm has no mask and always pulls the pin low.
// - Mask bit zero blocks a source, one lets it drive the pin.
// - Pin follows live unmasked alarms and releases when they end.
// - Status in bits 7..4, bit 3 reserved, masks in bits 2..0.
// - LED-loop alarm when actual current exceeds seven eighths of the drive setting.
// - Trip point is 200 C minus 9 degrees per code step.
// - Index amplifier enable bit 2 on at one, reset default one.
// - Interpolation comparator bit 1 active low, reset default zero.
// - Index comparator bit 2 active low, reset default zero.
// - Miscellaneous register bits 5..4 select maintenance outputs.
// - Maintenance code 00 disables, 11 enables, others prohibited.
// - Supply rise sets power-up status and pulls pin until sequence done.
`timescale 1ns/1ps
module alarm_interrupt_control (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Alarm sources
  input wire logic powerup_busy,
  input wire logic led_closed_loop,
  input wire logic [6:0] led_drive_setting,
  input wire logic [6:0] led_drive_actual,
  input wire logic [8:0] junction_temp,
  // Interrupt pin, open drain
  input wire logic alarm_request_n_in,
  output logic alarm_request_n_out,
  output logic alarm_request_n_oe,
  // Signal-path and power control
  output logic index_amp_on,
  output logic interp_comparator_off,
  output logic index_comparator_off,
  output logic maintenance_enable,
  output logic circuits_off,
  output logic [3:0] sensor_accuracy_trim
);

  // ----------------------------------------
  // Synchronised sources
  // ----------------------------------------
  // Power-up busy resets high so the alarm is seen from the first cycle.
  logic [3:0] raw_lvl;
  logic [3:0] sync_lvl;
  logic [7:0] tmp_unused;

  assign raw_lvl = {powerup_busy, led_closed_loop, 2'h0};

  pin_sync #(.WIDTH(4), .INIT(4'h8)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din(raw_lvl),
    .dout(sync_lvl)
  );

  // Multi-bit analog readouts are assumed stable; two flops still guard them.
  typedef struct packed {
    logic [6:0] act_m;
    logic [6:0] act_s;
    logic [8:0] tmp_m;
    logic [8:0] tmp_s;
    logic shutdown_latch;
  } mon_state_t;

  mon_state_t m_q;
  mon_state_t m_d;

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  alarm_reg_if rif ();
  logic [3:0] live_alarm;
  logic [7:0] mask_status;
  logic [7:0] trip_cfg;
  logic [7:0] amp_cfg;
  logic [7:0] cmp_cfg;
  logic [7:0] maint_cfg;

  assign rif.wr_en = reg_wr_en;
  assign rif.rd_en = reg_rd_en;
  assign rif.addr = reg_addr;
  assign rif.wdata = reg_wdata;
  assign reg_rdata = rif.rdata;

  alarm_regs u_regs (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .bus(rif.bank),
    .live_alarm(live_alarm),
    .mask_status(mask_status),
    .trip_cfg(trip_cfg),
    .amp_cfg(amp_cfg),
    .cmp_cfg(cmp_cfg),
    .maint_cfg(maint_cfg)
  );

  // ----------------------------------------
  // Alarm detection
  // ----------------------------------------
  function automatic logic [8:0] trip_deg(input logic [3:0] code);
    trip_deg = 9'(alarm_pkg::TRIP_BASE_DEG - alarm_pkg::TRIP_STEP_DEG * int'(code));
  endfunction : trip_deg

  logic powerup_alarm;
  logic led_alarm;
  logic thermal_alarm;
  logic over_temp;
  logic [9:0] act_x8;
  logic [9:0] set_x7;

  assign act_x8 = {m_q.act_s, 3'h0};
  assign set_x7 = 10'({3'h0, led_drive_setting} * 10'd7);

  assign powerup_alarm = sync_lvl[3];
  // Drive above 7/8 of led_drive_setting while in closed loop
  assign led_alarm = sync_lvl[2] && (act_x8 > set_x7);
  assign thermal_alarm = m_q.tmp_s > trip_deg(trip_cfg[3:0]);
  assign over_temp = m_q.tmp_s > 9'(alarm_pkg::SHUTDOWN_DEG);

  always_comb begin
    m_d.act_m = led_drive_actual;
    m_d.act_s = m_q.act_m;
    m_d.tmp_m = junction_temp;
    m_d.tmp_s = m_q.tmp_m;
    // Only the reset removes the shutdown latch
    m_d.shutdown_latch = m_q.shutdown_latch | over_temp;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign live_alarm = {powerup_alarm, led_alarm, thermal_alarm, m_q.shutdown_latch};

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  logic irq_active;
  assign irq_active = powerup_alarm
    | (led_alarm & mask_status[alarm_pkg::LED_LOOP_MASK_BIT])
    | (thermal_alarm & mask_status[alarm_pkg::THERMAL_ALARM_MASK_BIT])
    | (m_q.shutdown_latch & mask_status[alarm_pkg::SHUTDOWN_MASK_BIT]);

  // Open drain: only ever drive low, release otherwise
  assign alarm_request_n_out = 1'b0;
  assign alarm_request_n_oe = irq_active;
  assign tmp_unused = {7'h0, alarm_request_n_in};

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  assign circuits_off = m_q.shutdown_latch;
  assign index_amp_on = amp_cfg[alarm_pkg::INDEX_AMP_ON_BIT] & ~circuits_off;
  assign interp_comparator_off = cmp_cfg[alarm_pkg::INTERP_COMPARATOR_OFF_BIT]
    | circuits_off;
  assign index_comparator_off = cmp_cfg[alarm_pkg::INDEX_COMPARATOR_OFF_BIT]
    | circuits_off;
  // Prohibited codes leave the outputs off
  assign maintenance_enable = (maint_cfg[alarm_pkg::MAINT_SEL_LSB +: 2]
    == alarm_pkg::MAINT_ENABLED) & ~circuits_off;
  assign sensor_accuracy_trim = trip_cfg[7:4];

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Port widths are fixed; these guard the package figures that feed them
  if (alarm_pkg::TRIP_CODE_WIDTH != 4) begin : g_trip_width_check
    $error("trip code field must be four bits wide");
  end
  if (alarm_pkg::TRIP_BASE_DEG < alarm_pkg::TRIP_STEP_DEG * 15) begin : g_trip_range_check
    $error("trip decode would go below zero");
  end
  if (alarm_pkg::SHUTDOWN_DEG >= 2 ** alarm_pkg::TEMP_WIDTH) begin : g_shutdown_check
    $error("shutdown point outside the temperature range");
  end
  if (alarm_pkg::MAINT_SEL_LSB > 6) begin : g_maint_check
    $error("maintenance field runs off the register");
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_over;
    over_temp;
  endsequence
  sequence s_cleared_later;
    !over_temp [*2];
  endsequence

  shutdown_latch_a: assert property (s_over ##1 s_cleared_later |-> m_q.shutdown_latch)
    else $error("shutdown latch dropped");
  shutdown_off_a: assert property (m_q.shutdown_latch |-> circuits_off && !index_amp_on)
    else $error("circuits not off in shutdown");
  powerup_pin_a: assert property (powerup_alarm |-> alarm_request_n_oe)
    else $error("power-up alarm not on pin");
  masked_pin_a: assert property (!powerup_alarm && mask_status[2:0] == 3'h0
    |-> !alarm_request_n_oe)
    else $error("masked alarm drove pin");
  pin_release_a: assert property (live_alarm == 4'h0 |-> !alarm_request_n_oe)
    else $error("pin held without alarm");
  sticky_status_a: assert property (live_alarm[2] ##1 !rif.status_read
    |=> mask_status[alarm_pkg::LED_LOOP_STATUS_BIT])
    else $error("led status lost");
  status_set_a: assert property (thermal_alarm
    |=> mask_status[alarm_pkg::THERMAL_ALARM_STATUS_BIT])
    else $error("thermal status not set");
  maint_code_a: assert property (maint_cfg[5:4] != 2'h3 |-> !maintenance_enable)
    else $error("maintenance enabled by bad code");
  led_loop_a: assert property (!sync_lvl[2] |-> !led_alarm)
    else $error("led alarm in open loop");

  // Status bits: set, hold and clear
  sequence s_status_read;
    rif.status_read;
  endsequence
  sequence s_no_read;
    !rif.status_read;
  endsequence

  // Two samples of the alarm keep the release edge of reset out of the check
  powerup_status_a: assert property (powerup_alarm ##1 powerup_alarm
    |=> mask_status[alarm_pkg::POWERUP_STATUS_BIT])
    else $error("power-up status not set");
  led_status_a: assert property (led_alarm
    |=> mask_status[alarm_pkg::LED_LOOP_STATUS_BIT])
    else $error("led status not set");
  shutdown_status_a: assert property (m_q.shutdown_latch
    |=> mask_status[alarm_pkg::SHUTDOWN_STATUS_BIT])
    else $error("shutdown status not set");
  status_hold_a: assert property (s_no_read
    |=> (mask_status[7:4] & $past(mask_status[7:4])) == $past(mask_status[7:4]))
    else $error("status bit cleared without a read");
  read_clear_a: assert property (s_status_read ##0 (live_alarm == 4'h0)
    |=> mask_status[7:4] == 4'h0)
    else $error("status not cleared by read");
  read_data_a: assert property (s_status_read
    |=> reg_rdata == $past(mask_status))
    else $error("read data not the status before the clear");
  rdata_stable_a: assert property (!rif.rd_en |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  reserved_bit_a: assert property (mask_status[3] == 1'b0)
    else $error("reserved bit set");
  mask_write_a: assert property (
    rif.wr_en && rif.addr == alarm_pkg::ALARM_MASK_STATUS_ADDR
    |=> mask_status[2:0] == $past(rif.wdata[2:0]))
    else $error("mask write lost");

  // Pin drive per source
  led_pin_a: assert property (
    led_alarm && mask_status[alarm_pkg::LED_LOOP_MASK_BIT] |-> alarm_request_n_oe)
    else $error("unmasked led alarm not on pin");
  thermal_pin_a: assert property (
    thermal_alarm && mask_status[alarm_pkg::THERMAL_ALARM_MASK_BIT] |-> alarm_request_n_oe)
    else $error("unmasked thermal alarm not on pin");
  shutdown_pin_a: assert property (
    m_q.shutdown_latch && mask_status[alarm_pkg::SHUTDOWN_MASK_BIT] |-> alarm_request_n_oe)
    else $error("unmasked shutdown not on pin");

  // Shutdown and path control
  shutdown_set_a: assert property (over_temp |=> m_q.shutdown_latch)
    else $error("shutdown not latched");
  shutdown_hold_a: assert property (m_q.shutdown_latch |=> m_q.shutdown_latch)
    else $error("shutdown latch released");
  path_off_a: assert property (circuits_off
    |-> interp_comparator_off && index_comparator_off && !maintenance_enable)
    else $error("signal path on in shutdown");
  maint_on_a: assert property (
    maint_cfg[5:4] == alarm_pkg::MAINT_ENABLED && !circuits_off |-> maintenance_enable)
    else $error("maintenance outputs not enabled");
  // Decode checked as temperature plus steps against the base, no subtraction
  thermal_trip_a: assert property (thermal_alarm == (
    10'(m_q.tmp_s) + 10'(alarm_pkg::TRIP_STEP_DEG) * 10'(trip_cfg[3:0])
    > 10'(alarm_pkg::TRIP_BASE_DEG)))
    else $error("thermal alarm off its trip point");

endmodule : alarm_interrupt_control

// >>> rtl/alarm_regs.sv
/*
  Register bank: thermal trip, mask/status, amplifier enable, comparator
  disable and miscellaneous control. Status bits are sticky and clear on a
  read of the mask/status register, with a same-cycle set winning.
  Assumes single-cycle read and write strobes on ref_clk.
*/
`timescale 1ns/1ps
module alarm_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register access
  alarm_reg_if.bank bus,
  // Alarm levels and register contents
  input wire logic [3:0] live_alarm,
  output logic [7:0] mask_status,
  output logic [7:0] trip_cfg,
  output logic [7:0] amp_cfg,
  output logic [7:0] cmp_cfg,
  output logic [7:0] maint_cfg
);
  typedef struct packed {
    logic [7:0] trip;
    logic [3:0] status;
    logic [2:0] mask;
    logic [7:0] amp;
    logic [7:0] cmp;
    logic [7:0] maint;
    logic [7:0] rdata;
  } reg_state_t;

  reg_state_t r_q;
  reg_state_t r_d;
  logic status_rd;

  assign status_rd = bus.rd_en && bus.addr == alarm_pkg::ALARM_MASK_STATUS_ADDR;

  always_comb begin
    r_d = r_q;
    // Read returns current bits, clear takes effect after; live sets win
    if (status_rd) r_d.status = live_alarm;
    else r_d.status = r_q.status | live_alarm;
    if (bus.wr_en) begin
      unique case (bus.addr)
        alarm_pkg::THERMAL_TRIP_CONFIG_ADDR: r_d.trip = bus.wdata;
        alarm_pkg::ALARM_MASK_STATUS_ADDR: r_d.mask = bus.wdata[2:0];
        alarm_pkg::INDEX_AMP_ENABLE_ADDR: r_d.amp = bus.wdata;
        alarm_pkg::COMPARATOR_DISABLE_ADDR: r_d.cmp = bus.wdata;
        alarm_pkg::MISCELLANEOUS_CONTROL_ADDR: r_d.maint = bus.wdata;
        default: r_d.trip = r_q.trip;
      endcase
    end
    if (bus.rd_en) begin
      unique case (bus.addr)
        alarm_pkg::THERMAL_TRIP_CONFIG_ADDR: r_d.rdata = r_q.trip;
        alarm_pkg::ALARM_MASK_STATUS_ADDR: r_d.rdata = {r_q.status, 1'b0, r_q.mask};
        alarm_pkg::INDEX_AMP_ENABLE_ADDR: r_d.rdata = r_q.amp;
        alarm_pkg::COMPARATOR_DISABLE_ADDR: r_d.rdata = r_q.cmp;
        alarm_pkg::MISCELLANEOUS_CONTROL_ADDR: r_d.rdata = r_q.maint;
        default: r_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r_q.trip <= alarm_pkg::THERMAL_TRIP_RESET;
      r_q.status <= 4'h0;
      r_q.mask <= alarm_pkg::MASK_RESET[2:0];
      r_q.amp <= alarm_pkg::INDEX_AMP_RESET;
      r_q.cmp <= alarm_pkg::COMPARATOR_RESET;
      r_q.maint <= alarm_pkg::MAINT_CTRL_RESET;
      r_q.rdata <= 8'h00;
    end else begin
      r_q <= r_d;
    end
  end

  assign bus.rdata = r_q.rdata;
  assign bus.status_read = status_rd;
  assign mask_status = {r_q.status, 1'b0, r_q.mask};
  assign trip_cfg = r_q.trip;
  assign amp_cfg = r_q.amp;
  assign cmp_cfg = r_q.cmp;
  assign maint_cfg = r_q.maint;
endmodule : alarm_regs

// >>> verification/reg_host.sv
/*
  Behavioural host on the far side of the register port: single-cycle
  write and read strobes, plus a read-modify-write of the trip register.
  Assumes reads answer one cycle after the strobe.
*/
`timescale 1ns/1ps
module reg_host (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic wr_en,
  output logic rd_en,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    // Released data shows no stale value
    wdata <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : read_reg

  // Trim must survive a trip-point change
  task automatic trip_update(input logic [3:0] code);
    logic [7:0] cur;
    read_reg(alarm_pkg::THERMAL_TRIP_CONFIG_ADDR, cur);
    write_reg(alarm_pkg::THERMAL_TRIP_CONFIG_ADDR, {cur[7:4], code});
  endtask : trip_update
endmodule : reg_host

// >>> verification/alarm_interrupt_control_test.sv
/*
  Self-checking bench for the alarm and interrupt control block.
  Assumes the reg_host model drives the register port; pin has a pull-up.
*/
`timescale 1ns/1ps
module alarm_interrupt_control_test;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic powerup_busy = 1'b1;
  logic led_closed_loop = 1'b0;
  logic [6:0] led_drive_setting = 7'h40;
  logic [6:0] led_drive_actual = 7'h00;
  logic [8:0] junction_temp = 9'h019;
  logic reg_wr_en, reg_rd_en, irq_out, irq_oe, amp_on, interp_off, index_off, maint_en, off;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic [3:0] trim;
  logic irq_pin_n;
  logic [7:0] paths;
  int num_errors = 0;
  int total_checks = 0;

  always #2.5 ref_clk = ~ref_clk;
  assign irq_pin_n = (irq_oe && !irq_out) ? 1'b0 : 1'b1;
  assign paths = {4'h0, amp_on, interp_off, index_off, maint_en};

  reg_host host (.ref_clk(ref_clk), .wr_en(reg_wr_en), .rd_en(reg_rd_en), .addr(reg_addr),
    .wdata(reg_wdata), .rdata(reg_rdata));

  alarm_interrupt_control dut (.ref_clk(ref_clk), .rstn(rstn), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .powerup_busy(powerup_busy), .led_closed_loop(led_closed_loop),
    .led_drive_setting(led_drive_setting), .led_drive_actual(led_drive_actual),
    .junction_temp(junction_temp), .alarm_request_n_in(irq_pin_n),
    .alarm_request_n_out(irq_out), .alarm_request_n_oe(irq_oe), .index_amp_on(amp_on),
    .interp_comparator_off(interp_off), .index_comparator_off(index_off),
    .maintenance_enable(maint_en), .circuits_off(off), .sensor_accuracy_trim(trim));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_byte(name, {7'h00, exp}, {7'h00, got});
  endtask : check_bit

  task automatic expect_reg(input logic [15:0] a, input logic [7:0] exp);
    host.read_reg(a, rd);
    check_byte($sformatf("reg %h", a), exp, rd);
  endtask : expect_reg

  // Two sync flops plus status edge, with margin
  task automatic settle();
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    settle();
    check_bit("pin in power-up", 1'b0, irq_pin_n);
    @(posedge ref_clk) powerup_busy <= 1'b0;
    settle();
    check_bit("pin after power-up", 1'b1, irq_pin_n);
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h80);
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h00);
    expect_reg(alarm_pkg::THERMAL_TRIP_CONFIG_ADDR, 8'h00);
    expect_reg(alarm_pkg::INDEX_AMP_ENABLE_ADDR, 8'hFF);
    expect_reg(alarm_pkg::COMPARATOR_DISABLE_ADDR, 8'h00);
    expect_reg(alarm_pkg::MISCELLANEOUS_CONTROL_ADDR, 8'h01);
    check_byte("path outputs", 8'h08, paths);
    check_bit("off at start", 1'b0, off);
    host.write_reg(16'h088C, 8'h55);
    expect_reg(16'h088C, 8'h00);
    host.write_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'hFF);
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h07);
    host.write_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h00);
    // Thermal alarm: code 5 trips above 155
    host.write_reg(alarm_pkg::THERMAL_TRIP_CONFIG_ADDR, 8'hA0);
    host.trip_update(4'h5);
    expect_reg(alarm_pkg::THERMAL_TRIP_CONFIG_ADDR, 8'hA5);
    check_byte("trim", 8'h0A, {4'h0, trim});
    @(posedge ref_clk) junction_temp <= 9'd155;
    settle();
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h00);
    @(posedge ref_clk) junction_temp <= 9'd156;
    settle();
    check_bit("pin masked", 1'b1, irq_pin_n);
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h20);
    host.write_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h02);
    settle();
    check_bit("pin thermal", 1'b0, irq_pin_n);
    @(posedge ref_clk) junction_temp <= 9'd150;
    settle();
    check_bit("pin released", 1'b1, irq_pin_n);
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h22);
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h02);
    // LED loop: 56 of 64 is exactly seven eighths, 57 is above
    @(posedge ref_clk);
    led_closed_loop <= 1'b1;
    led_drive_actual <= 7'd56;
    settle();
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h02);
    @(posedge ref_clk) led_drive_actual <= 7'd57;
    settle();
    check_bit("pin led masked", 1'b1, irq_pin_n);
    host.write_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h06);
    settle();
    check_bit("pin led", 1'b0, irq_pin_n);
    @(posedge ref_clk) led_closed_loop <= 1'b0;
    settle();
    check_bit("pin led end", 1'b1, irq_pin_n);
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h46);
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h06);
    // Path enables: reserved bits kept at defaults
    host.write_reg(alarm_pkg::INDEX_AMP_ENABLE_ADDR, 8'hFB);
    host.write_reg(alarm_pkg::COMPARATOR_DISABLE_ADDR, 8'h02);
    host.write_reg(alarm_pkg::MISCELLANEOUS_CONTROL_ADDR, 8'h31);
    #1;
    check_byte("path set", 8'h05, paths);
    host.write_reg(alarm_pkg::COMPARATOR_DISABLE_ADDR, 8'h04);
    host.write_reg(alarm_pkg::MISCELLANEOUS_CONTROL_ADDR, 8'h11);
    #1;
    check_byte("path set2", 8'h02, paths);
    host.write_reg(alarm_pkg::MISCELLANEOUS_CONTROL_ADDR, 8'h21);
    #1;
    check_bit("maint 10", 1'b0, maint_en);
    host.write_reg(alarm_pkg::INDEX_AMP_ENABLE_ADDR, 8'hFF);
    host.write_reg(alarm_pkg::COMPARATOR_DISABLE_ADDR, 8'h00);
    host.write_reg(alarm_pkg::MISCELLANEOUS_CONTROL_ADDR, 8'h31);
    // Shutdown latches past the temperature drop
    host.write_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h01);
    @(posedge ref_clk) junction_temp <= 9'd166;
    settle();
    check_byte("shutdown", 8'h13, {3'h0, off, irq_pin_n, amp_on, interp_off, index_off});
    check_bit("maint off", 1'b0, maint_en);
    @(posedge ref_clk) junction_temp <= 9'd025;
    settle();
    check_byte("latched", 8'h10, {3'h0, off, irq_pin_n, 3'h0});
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h31);
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h11);
    @(posedge ref_clk) rstn <= 1'b0;
    @(posedge ref_clk) rstn <= 1'b1;
    settle();
    check_bit("off after reset", 1'b0, off);
    // Power-up alarm is seen for two cycles after reset; shutdown status gone
    expect_reg(alarm_pkg::ALARM_MASK_STATUS_ADDR, 8'h80);
    expect_reg(alarm_pkg::MISCELLANEOUS_CONTROL_ADDR, 8'h01);
    complete_run();
  end
endmodule : alarm_interrupt_control_test
